/* File: core/tcm_timer_top.sv */
// dual timer/counter with apb register access
`timescale 1ns/1ns
`default_nettype none
module tcm_timer_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // external pins
  input wire logic ext_irq0_pin_i,
  input wire logic ext_irq1_pin_i,
  input wire logic t0_count_pin_i,
  input wire logic t1_count_pin_i,
  // interrupt request and vector acknowledge
  input wire logic t0_irq_vector_i,
  input wire logic t1_irq_vector_i,
  output logic t0_irq_o,
  output logic t1_irq_o,
  // timer 1 overflow pulse for the serial port
  output logic t1_baud_tick_o
);

  // register state
  logic [7:0] t0_low_byte_q;
  logic [7:0] t0_high_byte_q;
  logic [7:0] t1_low_byte_q;
  logic [7:0] t1_high_byte_q;
  logic [7:0] timer_mode_reg_q;
  logic t0_run_bit_q;
  logic t1_run_bit_q;
  logic t0_overflow_flag_q;
  logic t1_overflow_flag_q;
  logic [7:0] irq_enable_reg_q;
  logic [2:0] div_q;
  logic per_cycle_q;

  // synchronised pins
  logic [3:0] pins_raw;
  logic [3:0] pins_sync;

  // bus decode
  logic wr_en;
  logic setup;
  logic wr_ctl;
  logic wr_mode;
  logic wr_t0lo;
  logic wr_t0hi;
  logic wr_t1lo;
  logic wr_t1hi;
  logic wr_ien;
  logic [31:0] rd_data;
  logic rd_err;

  // counting
  logic [1:0] t0_mode;
  logic [1:0] t1_mode;
  logic t0_split;
  logic ev0;
  logic ev1;
  logic en0;
  logic en1;
  logic inc0;
  logic inc1;
  logic inc0_hi;
  logic ovf0;
  logic ovf0_hi;
  logic ovf1;
  logic [16:0] nx0;
  logic [16:0] nx1;

  // one counting step of a timer, returns {overflow, high, low}
  function automatic logic [16:0] tcm_step(
    input logic [1:0] md,
    input logic [7:0] lo,
    input logic [7:0] hi
  );
    logic [16:0] r;
    logic [15:0] w;
    logic c;
    r = {1'b0, hi, lo};
    w = 16'h0000;
    c = 1'b0;
    case (md)
      tcm_pkg::MODE_13BIT: begin
        // upper three low bits kept, take no part
        c = (lo[4:0] == 5'h1F);
        r[4:0] = 5'(lo[4:0] + 5'h01);
        r[15:8] = c ? 8'(hi + 8'h01) : hi;
        r[16] = c && (hi == 8'hFF);
      end
      tcm_pkg::MODE_16BIT: begin
        w = 16'({hi, lo} + 16'h0001);
        r = {({hi, lo} == 16'hFFFF), w};
      end
      tcm_pkg::MODE_RELOAD: begin
        // reload from high byte, high byte untouched
        r[7:0] = (lo == 8'hFF) ? hi : 8'(lo + 8'h01);
        r[16] = (lo == 8'hFF);
      end
      default: begin
        // split mode: low byte as plain 8-bit timer
        r[7:0] = 8'(lo + 8'h01);
        r[16] = (lo == 8'hFF);
      end
    endcase
    return r;
  endfunction : tcm_step

  // peripheral cycle divider, one strobe every six clocks
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_q <= 3'h0;
      per_cycle_q <= 1'b0;
    end else begin
      per_cycle_q <= (div_q == tcm_pkg::PER_DIV_LAST);
      div_q <= (div_q == tcm_pkg::PER_DIV_LAST) ? 3'h0 : 3'(div_q + 3'h1);
    end
  end

  // pin synchronisers
  assign pins_raw = {t1_count_pin_i, t0_count_pin_i, ext_irq1_pin_i, ext_irq0_pin_i};

  for (genvar g = 0; g < 4; g++) begin : g_sync
    tcm_sync3 u_sync (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .pin_i(pins_raw[g]),
      .level_o(pins_sync[g])
    );
  end

  // count event sources
  tcm_cnt_src u_src0 (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .per_cycle_i(per_cycle_q),
    .counter_sel_i(timer_mode_reg_q[tcm_pkg::MOD_T0_SRC]),
    .pin_level_i(pins_sync[2]),
    .event_o(ev0)
  );

  tcm_cnt_src u_src1 (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .per_cycle_i(per_cycle_q),
    .counter_sel_i(timer_mode_reg_q[tcm_pkg::MOD_T1_SRC]),
    .pin_level_i(pins_sync[3]),
    .event_o(ev1)
  );

  // mode and enable decode
  assign t0_mode = {timer_mode_reg_q[tcm_pkg::MOD_T0_HI], timer_mode_reg_q[tcm_pkg::MOD_T0_LO]};
  assign t1_mode = {timer_mode_reg_q[tcm_pkg::MOD_T1_HI], timer_mode_reg_q[tcm_pkg::MOD_T1_LO]};
  assign t0_split = (t0_mode == tcm_pkg::MODE_SPLIT);

  // run alone, or run with pin high when gated
  assign en0 = t0_run_bit_q && (!timer_mode_reg_q[tcm_pkg::MOD_T0_GATE] || pins_sync[0]);

  // timer 1 halts in its mode 3; its run bit is lent out in split mode
  assign en1 = (t1_mode != tcm_pkg::MODE_SPLIT)
               && (t0_split || t1_run_bit_q)
               && (!timer_mode_reg_q[tcm_pkg::MOD_T1_GATE] || pins_sync[1]);

  assign inc0 = en0 && ev0;
  assign inc1 = en1 && ev1;

  // split high byte counts peripheral cycles under timer 1 run
  assign inc0_hi = t0_split && t1_run_bit_q && per_cycle_q;

  assign nx0 = tcm_step(t0_mode, t0_low_byte_q, t0_high_byte_q);
  assign nx1 = tcm_step(t1_mode, t1_low_byte_q, t1_high_byte_q);

  assign ovf0 = inc0 && nx0[16];
  assign ovf0_hi = inc0_hi && (t0_high_byte_q == 8'hFF);
  assign ovf1 = inc1 && nx1[16];

  // apb decode: registered answer, one wait-free access cycle
  assign setup = psel_i && !penable_i;
  assign wr_en = psel_i && penable_i && pready_o && pwrite_i;

  always_comb begin
    wr_ctl = 1'b0;
    wr_mode = 1'b0;
    wr_t0lo = 1'b0;
    wr_t0hi = 1'b0;
    wr_t1lo = 1'b0;
    wr_t1hi = 1'b0;
    wr_ien = 1'b0;
    rd_data = 32'h00000000;
    rd_err = 1'b0;
    if (paddr_i == tcm_pkg::ADDR_CONTROL) begin
      wr_ctl = wr_en;
      rd_data[tcm_pkg::CTL_T0_RUN] = t0_run_bit_q;
      rd_data[tcm_pkg::CTL_T0_FLAG] = t0_overflow_flag_q;
      rd_data[tcm_pkg::CTL_T1_RUN] = t1_run_bit_q;
      rd_data[tcm_pkg::CTL_T1_FLAG] = t1_overflow_flag_q;
    end else if (paddr_i == tcm_pkg::ADDR_MODE) begin
      wr_mode = wr_en;
      rd_data[7:0] = timer_mode_reg_q;
    end else if (paddr_i == tcm_pkg::ADDR_T0_LOW) begin
      wr_t0lo = wr_en;
      rd_data[7:0] = t0_low_byte_q;
    end else if (paddr_i == tcm_pkg::ADDR_T0_HIGH) begin
      wr_t0hi = wr_en;
      rd_data[7:0] = t0_high_byte_q;
    end else if (paddr_i == tcm_pkg::ADDR_T1_LOW) begin
      wr_t1lo = wr_en;
      rd_data[7:0] = t1_low_byte_q;
    end else if (paddr_i == tcm_pkg::ADDR_T1_HIGH) begin
      wr_t1hi = wr_en;
      rd_data[7:0] = t1_high_byte_q;
    end else if (paddr_i == tcm_pkg::ADDR_IRQ_ENABLE) begin
      wr_ien = wr_en;
      rd_data[7:0] = irq_enable_reg_q;
    end else begin
      rd_err = 1'b1;
    end
  end

  // apb answer flops
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else if (setup) begin
      pready_o <= 1'b1;
      pslverr_o <= rd_err;
      prdata_o <= pwrite_i ? 32'h00000000 : rd_data;
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // mode and interrupt enable registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      timer_mode_reg_q <= tcm_pkg::RST_BYTE;
      irq_enable_reg_q <= tcm_pkg::RST_BYTE;
    end else begin
      if (wr_mode) begin
        timer_mode_reg_q <= pwdata_i[7:0];
      end
      if (wr_ien) begin
        irq_enable_reg_q <= pwdata_i[7:0];
      end
    end
  end

  // run bits only gate counting, count bytes are left alone
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      t0_run_bit_q <= 1'b0;
      t1_run_bit_q <= 1'b0;
    end else if (wr_ctl) begin
      t0_run_bit_q <= pwdata_i[tcm_pkg::CTL_T0_RUN];
      t1_run_bit_q <= pwdata_i[tcm_pkg::CTL_T1_RUN];
    end
  end

  // timer 0 count bytes, software write wins over counting
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      t0_low_byte_q <= tcm_pkg::RST_BYTE;
      t0_high_byte_q <= tcm_pkg::RST_BYTE;
    end else begin
      if (wr_t0lo) begin
        t0_low_byte_q <= pwdata_i[7:0];
      end else if (inc0) begin
        t0_low_byte_q <= nx0[7:0];
      end
      if (wr_t0hi) begin
        t0_high_byte_q <= pwdata_i[7:0];
      end else if (t0_split) begin
        if (inc0_hi) begin
          t0_high_byte_q <= 8'(t0_high_byte_q + 8'h01);
        end
      end else if (inc0) begin
        t0_high_byte_q <= nx0[15:8];
      end
    end
  end

  // timer 1 count bytes
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      t1_low_byte_q <= tcm_pkg::RST_BYTE;
      t1_high_byte_q <= tcm_pkg::RST_BYTE;
    end else begin
      if (wr_t1lo) begin
        t1_low_byte_q <= pwdata_i[7:0];
      end else if (inc1) begin
        t1_low_byte_q <= nx1[7:0];
      end
      if (wr_t1hi) begin
        t1_high_byte_q <= pwdata_i[7:0];
      end else if (inc1) begin
        t1_high_byte_q <= nx1[15:8];
      end
    end
  end

  // overflow flags: set beats software clear and vector clear
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      t0_overflow_flag_q <= 1'b0;
      t1_overflow_flag_q <= 1'b0;
    end else begin
      if (ovf0) begin
        t0_overflow_flag_q <= 1'b1;
      end else if (t0_irq_vector_i) begin
        t0_overflow_flag_q <= 1'b0;
      end else if (wr_ctl) begin
        t0_overflow_flag_q <= pwdata_i[tcm_pkg::CTL_T0_FLAG];
      end
      // split high byte owns this flag while timer 0 is in mode 3
      if (t0_split ? ovf0_hi : ovf1) begin
        t1_overflow_flag_q <= 1'b1;
      end else if (t1_irq_vector_i) begin
        t1_overflow_flag_q <= 1'b0;
      end else if (wr_ctl) begin
        t1_overflow_flag_q <= pwdata_i[tcm_pkg::CTL_T1_FLAG];
      end
    end
  end

  // interrupt requests and baud tick
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      t0_irq_o <= 1'b0;
      t1_irq_o <= 1'b0;
      t1_baud_tick_o <= 1'b0;
    end else begin
      t0_irq_o <= t0_overflow_flag_q && irq_enable_reg_q[tcm_pkg::IEN_T0]
                  && irq_enable_reg_q[tcm_pkg::IEN_GLOBAL];
      t1_irq_o <= t1_overflow_flag_q && irq_enable_reg_q[tcm_pkg::IEN_T1]
                  && irq_enable_reg_q[tcm_pkg::IEN_GLOBAL];
      t1_baud_tick_o <= ovf1;
    end
  end

endmodule : tcm_timer_top
`default_nettype wire

/* File: core/tcm_pkg.sv */
// package of constants for the dual timer/counter block
package tcm_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_T0_LOW = 8'h08;
  localparam logic [7:0] ADDR_T0_HIGH = 8'h0C;
  localparam logic [7:0] ADDR_T1_LOW = 8'h10;
  localparam logic [7:0] ADDR_T1_HIGH = 8'h14;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h18;

  // control register fields
  localparam int CTL_T0_RUN = 4;
  localparam int CTL_T0_FLAG = 5;
  localparam int CTL_T1_RUN = 6;
  localparam int CTL_T1_FLAG = 7;

  // mode register fields (timer 1 uses the upper nibble)
  localparam int MOD_T0_LO = 0;
  localparam int MOD_T0_HI = 1;
  localparam int MOD_T0_SRC = 2;
  localparam int MOD_T0_GATE = 3;
  localparam int MOD_T1_LO = 4;
  localparam int MOD_T1_HI = 5;
  localparam int MOD_T1_SRC = 6;
  localparam int MOD_T1_GATE = 7;

  // interrupt enable register fields
  localparam int IEN_T0 = 1;
  localparam int IEN_T1 = 3;
  localparam int IEN_GLOBAL = 7;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;

  // timing: one peripheral cycle is six clocks
  localparam int PER_CYCLE_CLOCKS = 6;
  localparam logic [2:0] PER_DIV_LAST = 3'(PER_CYCLE_CLOCKS - 1);

  // operating modes
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;

endpackage : tcm_pkg

/* File: core/tcm_sync3.sv */
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module tcm_sync3 (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // pin in, clean level out
  input wire logic pin_i,
  output logic level_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // change accepted once second and third agree
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      level_o <= 1'b0;
    end else if (s2_q == s3_q) begin
      level_o <= s3_q;
    end
  end
endmodule : tcm_sync3
`default_nettype wire

/* File: core/tcm_cnt_src.sv */
// count event source: peripheral cycle or sampled pin falling edge
`timescale 1ns/1ns
`default_nettype none
module tcm_cnt_src (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // peripheral cycle strobe and source select
  input wire logic per_cycle_i,
  input wire logic counter_sel_i,
  input wire logic pin_level_i,
  // one-cycle count event
  output logic event_o
);
  logic prev_q;
  logic cur_q;

  // pin sampled once per peripheral cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev_q <= 1'b0;
      cur_q <= 1'b0;
    end else if (per_cycle_i) begin
      prev_q <= cur_q;
      cur_q <= pin_level_i;
    end
  end

  // one sample high, the next low: count once
  assign event_o = counter_sel_i ? (per_cycle_i && prev_q && !cur_q) : per_cycle_i;
endmodule : tcm_cnt_src
`default_nettype wire

/* File: bench/tcm_timer_sva.sv */
// assertion checker on the dual timer/counter top ports
`timescale 1ns/1ns
`default_nettype none
module tcm_timer_sva (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // interrupts and tick
  input wire logic t0_irq_vector_i,
  input wire logic t1_irq_vector_i,
  input wire logic t0_irq_o,
  input wire logic t1_irq_o,
  input wire logic t1_baud_tick_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic setup;
  assign setup = psel_i && !penable_i;
  answer_next_a: assert property (setup |=> pready_o)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  err_with_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  unmapped_err_a: assert property (setup && paddr_i > 8'h18 |=> pslverr_o)
    else $error("unmapped address not refused");
  mapped_ok_a: assert property (setup && paddr_i[1:0] == 2'h0 && paddr_i <= 8'h18
    |=> !pslverr_o)
    else $error("mapped address refused");
  data_upper_a: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  data_hold_a: assert property (!setup |=> $stable(prdata_o))
    else $error("read data changed outside setup");
  t0_vec_clear_a: assert property (t0_irq_vector_i |-> ##2 !t0_irq_o)
    else $error("timer 0 request not cleared");
  t1_vec_clear_a: assert property (t1_irq_vector_i |-> ##2 !t1_irq_o)
    else $error("timer 1 request not cleared");
  tick_space_a: assert property (t1_baud_tick_o |=> !t1_baud_tick_o [*5])
    else $error("overflow ticks too close");
endmodule : tcm_timer_sva
bind tcm_timer_top tcm_timer_sva u_sva (.clk_i, .resetn_i, .psel_i, .penable_i,
  .paddr_i, .prdata_o, .pready_o, .pslverr_o, .t0_irq_vector_i, .t1_irq_vector_i,
  .t0_irq_o, .t1_irq_o, .t1_baud_tick_o);
`default_nettype wire

/* File: bench/test_tcm_timer_top.sv */
// self-checking bench for the dual timer/counter
`timescale 1ns/1ns
`default_nettype none
module test_tcm_timer_top;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic ext_irq0_pin_i = 1'b0;
  logic ext_irq1_pin_i = 1'b0;
  logic t0_count_pin_i = 1'b0;
  logic t1_count_pin_i = 1'b0;
  logic t0_irq_vector_i = 1'b0;
  logic t1_irq_vector_i = 1'b0;
  logic t0_irq_o;
  logic t1_irq_o;
  logic t1_baud_tick_o;
  int bad_count = 0;
  int checks_done = 0;
  int n;
  logic [31:0] rv;
  logic [31:0] old;
  logic err;
  always #4 clk_i = ~clk_i;
  tcm_timer_top u_dut (.clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .ext_irq0_pin_i, .ext_irq1_pin_i,
    .t0_count_pin_i, .t1_count_pin_i, .t0_irq_vector_i, .t1_irq_vector_i,
    .t0_irq_o, .t1_irq_o, .t1_baud_tick_o);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer, held until ready is sampled
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rv = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask : xfer
  // clocks until the next timer 1 overflow tick
  task automatic wait_tick();
    n = 0;
    forever begin
      @(posedge clk_i);
      n++;
      if (t1_baud_tick_o === 1'b1) break;
    end
  endtask : wait_tick
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (5000) @(posedge clk_i);
    bad_count++;
    $display("Error at %0t: watchdog expired", $time);
    complete_run();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    // reset values, then the unmapped word
    for (int i = 0; i < 8; i++) begin
      xfer(1'b0, 8'(i * 4), 8'h00);
      chk({31'h0, err}, {31'h0, i == 7});
      chk(rv, 32'h0);
    end
    xfer(1'b1, 8'h08, 8'hA5);
    xfer(1'b0, 8'h08, 8'h00);
    chk(rv, 32'hA5);
    // timer 1 mode 0, four counts from overflow
    xfer(1'b1, 8'h14, 8'hFF);
    xfer(1'b1, 8'h10, 8'hFC);
    xfer(1'b1, 8'h00, 8'h40);
    wait_tick();
    xfer(1'b1, 8'h00, 8'h80);
    xfer(1'b0, 8'h00, 8'h00);
    chk(rv, 32'h80);
    xfer(1'b0, 8'h10, 8'h00);
    chk(rv & 32'h1F, 32'h0);
    xfer(1'b0, 8'h14, 8'h00);
    chk(rv, 32'h0);
    // request gated by both enables, cleared by vectoring
    xfer(1'b1, 8'h18, 8'h08);
    repeat (2) @(posedge clk_i);
    chk({31'h0, t1_irq_o}, 32'h0);
    xfer(1'b1, 8'h18, 8'h88);
    repeat (2) @(posedge clk_i);
    chk({31'h0, t1_irq_o}, 32'h1);
    t0_irq_vector_i <= 1'b1;
    t1_irq_vector_i <= 1'b1;
    @(posedge clk_i);
    t0_irq_vector_i <= 1'b0;
    t1_irq_vector_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({31'h0, t1_irq_o}, 32'h0);
    xfer(1'b0, 8'h00, 8'h00);
    chk(rv, 32'h0);
    // timer 1 mode 1 carry into high byte
    xfer(1'b1, 8'h04, 8'h10);
    xfer(1'b1, 8'h14, 8'hFF);
    xfer(1'b1, 8'h10, 8'hFD);
    xfer(1'b1, 8'h00, 8'h40);
    wait_tick();
    xfer(1'b1, 8'h00, 8'h00);
    xfer(1'b0, 8'h10, 8'h00);
    chk(rv, 32'h0);
    xfer(1'b0, 8'h14, 8'h00);
    chk(rv, 32'h0);
    // timer 1 mode 2 reload period and reload change
    xfer(1'b1, 8'h04, 8'h20);
    xfer(1'b1, 8'h14, 8'hF0);
    xfer(1'b1, 8'h10, 8'hF0);
    xfer(1'b1, 8'h00, 8'h40);
    wait_tick();
    wait_tick();
    chk(n, 96);
    xfer(1'b1, 8'h14, 8'hF8);
    wait_tick();
    wait_tick();
    chk(n, 48);
    xfer(1'b1, 8'h00, 8'h00);
    xfer(1'b0, 8'h14, 8'h00);
    chk(rv, 32'hF8);
    // timer 0 split, timer 1 held
    xfer(1'b1, 8'h04, 8'h33);
    xfer(1'b1, 8'h0C, 8'hFE);
    xfer(1'b0, 8'h10, 8'h00);
    old = rv;
    xfer(1'b1, 8'h00, 8'h40);
    repeat (30) @(posedge clk_i);
    xfer(1'b0, 8'h00, 8'h00);
    chk(rv, 32'hC0);
    xfer(1'b0, 8'h10, 8'h00);
    chk(rv, old);
    // split low byte counting pin falling edges
    xfer(1'b1, 8'h00, 8'h00);
    xfer(1'b1, 8'h04, 8'h37);
    xfer(1'b1, 8'h08, 8'hFE);
    xfer(1'b1, 8'h00, 8'h10);
    for (int i = 0; i < 3; i++) begin
      t0_count_pin_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      t0_count_pin_i <= 1'b0;
      repeat (12) @(posedge clk_i);
    end
    repeat (24) @(posedge clk_i);
    xfer(1'b0, 8'h08, 8'h00);
    chk(rv, 32'h01);
    xfer(1'b0, 8'h00, 8'h00);
    chk(rv, 32'h30);
    // timer 0 request under its own enable, cleared by vectoring
    xfer(1'b1, 8'h18, 8'h82);
    repeat (2) @(posedge clk_i);
    chk({31'h0, t0_irq_o}, 32'h1);
    t0_irq_vector_i <= 1'b1;
    @(posedge clk_i);
    t0_irq_vector_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({31'h0, t0_irq_o}, 32'h0);
    // gated timer 0 in mode 1
    xfer(1'b1, 8'h00, 8'h00);
    xfer(1'b1, 8'h04, 8'h09);
    xfer(1'b1, 8'h08, 8'h00);
    xfer(1'b1, 8'h00, 8'h10);
    repeat (40) @(posedge clk_i);
    xfer(1'b0, 8'h08, 8'h00);
    chk(rv, 32'h0);
    ext_irq0_pin_i <= 1'b1;
    repeat (40) @(posedge clk_i);
    xfer(1'b0, 8'h08, 8'h00);
    chk({31'h0, rv[7:0] > 8'h04}, 32'h1);
    // gated timer 1 counting pin edges, gate opened after two pulses
    xfer(1'b1, 8'h00, 8'h00);
    xfer(1'b1, 8'h04, 8'hD0);
    xfer(1'b1, 8'h10, 8'h00);
    xfer(1'b1, 8'h00, 8'h40);
    for (int i = 0; i < 4; i++) begin
      if (i == 2) begin
        repeat (24) @(posedge clk_i);
        ext_irq1_pin_i <= 1'b1;
      end
      t1_count_pin_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      t1_count_pin_i <= 1'b0;
      repeat (12) @(posedge clk_i);
    end
    repeat (24) @(posedge clk_i);
    xfer(1'b0, 8'h10, 8'h00);
    chk(rv, 32'h02);
    complete_run();
  end
endmodule : test_tcm_timer_top
`default_nettype wire
